// File: bench/adcseq_asserts.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
module adcseq_asserts
   import adcseq_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        host_transfer,
   input wire logic        conv_done,
   input wire logic        gain_stage_reset,
   input wire logic        osc_enable,
   input wire logic [4:0]  resolution,
   input wire logic [3:0]  gain_stage_bias_level,
   input wire logic [3:0]  converter_bias_level
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic       wr_set = psel && !penable && pwrite;
   wire logic [3:0] oversampling_ratio    = pwdata[3:0];
   // nel_log is two bits wide, so only the osr code can be out of range
   wire logic       osr_ok = oversampling_ratio >= ADCSEQ_OSR_LOG_MIN
                             && oversampling_ratio <= ADCSEQ_OSR_LOG_MAX;

   res_calc_a: assert property (
      wr_set && paddr == ADCSEQ_CONV_OFS && osr_ok |=> resolution ==
      {$past(oversampling_ratio), 1'b0} + 5'($past(pwdata[5:4])))
      else $error("resolution not taken from conv write");
   osr_range_a: assert property (
      wr_set && paddr == ADCSEQ_CONV_OFS && !osr_ok
      |=> pslverr && $stable(resolution))
      else $error("bad osr code not refused");
   res_bound_a: assert property (
      resolution >= 5'h06 && resolution <= 5'h17)
      else $error("resolution outside legal span");
   bias_map_a: assert property (
      wr_set && paddr == ADCSEQ_BIAS_OFS
      |=> gain_stage_bias_level == 4'h1 << $past(pwdata[1:0])
      && converter_bias_level == 4'h1 << $past(pwdata[3:2]))
      else $error("bias level does not match code");
   fe_reset_a: assert property (
      wr_set && paddr == ADCSEQ_FE_OFS |-> ##[1:2] gain_stage_reset)
      else $error("front end write gave no gain reset");
   wake_osc_a: assert property (
      host_transfer && !osc_enable |-> ##[1:2] osc_enable)
      else $error("oscillator not enabled on wake");
   sleep_quiet_a: assert property (
      !osc_enable |-> !conv_done)
      else $error("conversion pulse while asleep");
   bad_addr_a: assert property (
      psel && penable && paddr > ADCSEQ_IRQ_CLR_OFS |-> pslverr)
      else $error("unmapped access not refused");
endmodule

bind adc_conversion_sequencer adcseq_asserts chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .host_transfer, .conv_done, .gain_stage_reset, .osc_enable,
   .resolution, .gain_stage_bias_level, .converter_bias_level);

// File: bench/adcseq_host_model.sv
// host side model: wakes the device and times the completion pulse
`timescale 1ns/1ns
module adcseq_host_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic wake_go,
   input  wire logic conv_done,
   output logic      host_transfer,
   output int        n_pulse,
   output int        width,
   output int        period
);
   int run_w;
   int gap;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_transfer <= 1'b0;
         n_pulse <= 0;
         width <= 0;
         period <= 0;
         run_w <= 0;
         gap <= 0;
      end else begin
         // transfer follows the request one cycle later, held for as long as wake_go stays high
         host_transfer <= wake_go;
         gap <= gap + 1;
         if (conv_done)
            run_w <= run_w + 1;
         if (conv_done && run_w == 0) begin
            n_pulse <= n_pulse + 1;
            period <= gap;
            gap <= 1;
         end
         if (!conv_done && run_w != 0) begin
            width <= run_w;
            run_w <= 0;
         end
      end
   end
endmodule

// File: bench/tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module tb
   import adcseq_pkg::*;
;
   localparam int STUP = 20;
   localparam int OSC  = 10;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        host_transfer, conv_done, gain_stage_reset, osc_enable;
   logic        settled, irq, wake_go, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0]  resolution;
   logic [3:0]  gain_stage_bias_level, converter_bias_level;
   int          n_pulse, width, period, n_grst, k;
   int          n_mismatch, samples_checked;

   adc_conversion_sequencer #(.STARTUP_CYCLES(STUP), .OSC_CYCLES(OSC)) uut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .host_transfer, .conv_done, .gain_stage_reset,
      .osc_enable, .settled, .resolution, .gain_stage_bias_level,
      .converter_bias_level, .irq);
   adcseq_host_model host (.pclk, .presetn, .wake_go, .conv_done,
      .host_transfer, .n_pulse, .width, .period);

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // counted mid-cycle so the count has settled when a task returns
   always @(negedge pclk) if (gain_stage_reset) n_grst++;

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #(20 * 20000);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      {presetn, psel, penable, pwrite, wake_go} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_grst = 0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADCSEQ_CONV_OFS);
      chk("conv_rst", 32'(q[15:0]), 32'h6305);
      repeat (STUP + 5) @(posedge pclk);
      rd(ADCSEQ_STATUS_OFS);
      chk("state_sleep", 32'(q[2:0]), 32'h0);
      rd(ADCSEQ_IRQ_ST_OFS);
      chk("ready_irq", 32'(q[1]), 32'h1);
      wr(ADCSEQ_IRQ_EN_OFS, 32'h2);
      chk("irq_on", 32'(irq), 32'h1);
      wr(ADCSEQ_IRQ_EN_OFS, 32'h0);
      chk("irq_masked", 32'(irq), 32'h0);
      wr(ADCSEQ_IRQ_CLR_OFS, 32'h7);
      rd(ADCSEQ_IRQ_ST_OFS);
      chk("irq_clear", q, 32'h0);
      rd(12'h040);
      chk("unmapped", 32'(err), 32'h1);
      wake_go <= 1'b1;
      @(posedge pclk);
      wake_go <= 1'b0;
      repeat (OSC + 5) @(posedge pclk);
      rd(ADCSEQ_STATUS_OFS);
      chk("state_idle", 32'(q[2:0]), 32'h3);
      $display("test startup and wake done");
      for (int n = 0; n < 4; n++) begin
         wr(ADCSEQ_CONV_OFS, 32'(n) << 4 | 32'h3);
         chk("res", 32'(resolution), 32'(6 + n));
      end
      wr(ADCSEQ_CONV_OFS, 32'h2);
      chk("osr_low", 32'(err), 32'h1);
      chk("res_kept", 32'(resolution), 32'h9);
      wr(ADCSEQ_CONV_OFS, 32'hA);
      chk("res_max", 32'(resolution), 32'h14);
      for (int c = 0; c < 4; c++) begin
         wr(ADCSEQ_BIAS_OFS, 32'(c * 5));
         q = {gain_stage_bias_level, converter_bias_level};
         chk("bias", q, 32'h11 << c);
      end
      wr(ADCSEQ_CONV_OFS, 32'h3);
      for (int i = 0; i < 2; i++) begin
         k = n_grst;
         wr(ADCSEQ_FE_OFS, i ? 32'h700 : 32'h0);
         chk("gain_rst", 32'(n_grst - k), 32'h1);
         chk("unsettled", 32'(settled), 32'h0);
      end
      repeat (12) @(posedge pclk);
      chk("settled", 32'(settled), 32'h1);
      wr(ADCSEQ_CTRL_OFS, 32'h20);
      wr(ADCSEQ_FE_OFS, 32'h0);
      chk("bypass", 32'(settled), 32'h1);
      wr(ADCSEQ_CTRL_OFS, 32'h0);
      // host waits out the settling time before any start
      repeat (12) @(posedge pclk);
      $display("test config done");
      for (int n = 0; n < 4; n++) begin
         wr(ADCSEQ_CONV_OFS, 32'(n) << 4 | 32'h3);
         wr(ADCSEQ_CTRL_OFS, 32'h3);
         k = n_pulse;
         while (n_pulse < k + 2) @(posedge pclk);
         chk("period", 32'(period), 32'((1 << n) * 9 + 1));
         chk("width", 32'(width), 32'h1);
         wr(ADCSEQ_CTRL_OFS, 32'h0);
         repeat (80) @(posedge pclk);
      end
      rd(ADCSEQ_IRQ_ST_OFS);
      chk("eoc_irq", 32'(q[0]), 32'h1);
      $display("test conversion done");
      wr(ADCSEQ_CTRL_OFS, 32'h10);
      repeat (2) @(posedge pclk);
      chk("sleep", 32'(osc_enable), 32'h0);
      wr(ADCSEQ_IRQ_CLR_OFS, 32'h7);
      wr(ADCSEQ_CTRL_OFS, 32'h4);
      rd(ADCSEQ_STATUS_OFS);
      chk("swrst", 32'(q[2:0]), 32'h2);
      repeat (STUP + 5) @(posedge pclk);
      rd(ADCSEQ_IRQ_ST_OFS);
      chk("swrst_ready", 32'(q[1]), 32'h1);
      $display("test reset done");
      report_and_stop();
   end
endmodule

// File: src/adc_conversion_sequencer.sv
// conversion sequencer with apb registers and interrupts
`timescale 1ns/1ns
module adc_conversion_sequencer
   import adcseq_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYC,
   parameter int OSC_CYCLES     = OSC_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        host_transfer,
   output logic             conv_done,
   output logic             gain_stage_reset,
   output logic             osc_enable,
   output logic             settled,
   output logic [4:0]       resolution,
   output logic [3:0]       gain_stage_bias_level,
   output logic [3:0]       converter_bias_level,
   output logic             irq
);
   typedef struct packed {
      adcseq_state_t         state;
      adcseq_conv_cfg_t      cfg;
      adcseq_bias_t          bias;
      logic [7:0]            fs_div;
      logic                  cont;
      logic                  bypass;
      logic [4:0][7:0]       fe_reg;
      logic [CNT_W-1:0]      conv_cnt;
      logic [CNT_W-1:0]      settle_cnt;
      logic [31:0]           wait_cnt;
      logic                  done;
      logic                  pga_rst;
      logic [ADCSEQ_IRQ_W-1:0] irq_st;
      logic [ADCSEQ_IRQ_W-1:0] irq_en;
      logic [31:0]           rdata;
      logic                  err;
   } adcseq_st_t;

   adcseq_st_t st;
   adcseq_st_t next_st;
   logic       fs_tick;
   logic       setup;
   logic       wr;
   logic       rd;
   logic [CNT_W-1:0] conv_len;
   logic [CNT_W-1:0] osr_val;
   logic       cfg_ok;
   logic [ADCSEQ_IRQ_W-1:0] ev;

   assign setup = psel & ~penable;
   assign wr    = setup & pwrite;
   assign rd    = setup & ~pwrite;

   // fs enable runs only while the oscillator is up
   adcseq_fs_div u_fs_div (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (st.state != ADCSEQ_SLEEP),
      .div     (st.fs_div),
      .fs_tick (fs_tick)
   );

   adcseq_bias_map u_pga_bias (
      .sel   (st.bias.gain_stage_bias_sel),
      .level (gain_stage_bias_level)
   );

   adcseq_bias_map u_adc_bias (
      .sel   (st.bias.converter_bias_sel),
      .level (converter_bias_level)
   );

   assign osr_val = CNT_W'(1) << st.cfg.osr_log;
   // nel*(osr+1)+1
   assign conv_len = ((osr_val + CNT_W'(1)) << st.cfg.nel_log)
                     + CNT_W'(1);

   function automatic logic valid_cfg(input logic [3:0] o,
                                      input logic [1:0] n);
      valid_cfg = (o >= ADCSEQ_OSR_LOG_MIN) && (o <= ADCSEQ_OSR_LOG_MAX)
                  && (n <= ADCSEQ_NEL_LOG_MAX);
   endfunction

   assign cfg_ok = valid_cfg(pwdata[3:0], pwdata[5:4]);

   always_comb begin
      next_st = st;
      ev = '0;
      next_st.done = 1'b0;
      next_st.pga_rst = 1'b0;
      next_st.err = 1'b0;

      // settling counter in fs cycles since last gain reset
      if (fs_tick && st.settle_cnt != {CNT_W{1'b1}}) begin
         next_st.settle_cnt = st.settle_cnt + CNT_W'(1);
      end

      // state machine
      case (st.state)
         ADCSEQ_SLEEP: begin
            if (host_transfer) begin
               next_st.state = ADCSEQ_WAKING;
               next_st.wait_cnt = '0;
            end
         end
         ADCSEQ_WAKING: begin
            next_st.wait_cnt = st.wait_cnt + 32'h1;
            if (st.wait_cnt >= 32'(OSC_CYCLES - 1)) begin
               next_st.state = ADCSEQ_IDLE;
               ev[ADCSEQ_IRQ_READY] = 1'b1;
            end
         end
         ADCSEQ_STARTUP: begin
            next_st.wait_cnt = st.wait_cnt + 32'h1;
            if (st.wait_cnt >= 32'(STARTUP_CYCLES - 1)) begin
               next_st.state = ADCSEQ_SLEEP;
               ev[ADCSEQ_IRQ_READY] = 1'b1;
            end
         end
         ADCSEQ_IDLE: begin
         end
         ADCSEQ_CONV: begin
            if (fs_tick) begin
               next_st.conv_cnt = st.conv_cnt + CNT_W'(1);
               if (st.conv_cnt >= conv_len - CNT_W'(1)) begin
                  next_st.state = ADCSEQ_DONE;
                  next_st.conv_cnt = '0;
                  ev[ADCSEQ_IRQ_EOC] = 1'b1;
               end
            end
         end
         ADCSEQ_DONE: begin
            // pulse stands for one fs period
            if (fs_tick) begin
               next_st.state = st.cont ? ADCSEQ_CONV
                                       : ADCSEQ_IDLE;
               // pulse period is the first cycle of the next conversion
               if (st.cont) begin
                  next_st.conv_cnt = CNT_W'(1);
               end
            end
         end
         default: next_st.state = ADCSEQ_SLEEP;
      endcase

      // register writes, taken in the setup cycle
      if (wr) begin
         if (paddr == ADCSEQ_CTRL_OFS) begin
            next_st.cont = pwdata[ADCSEQ_CTRL_CONT];
            next_st.bypass = pwdata[ADCSEQ_CTRL_BYPASS];
            if (pwdata[ADCSEQ_CTRL_SWRST]) begin
               next_st.state = ADCSEQ_STARTUP;
               next_st.wait_cnt = '0;
               next_st.conv_cnt = '0;
            end else if (pwdata[ADCSEQ_CTRL_SLEEP]) begin
               next_st.state = ADCSEQ_SLEEP;
            end else if (pwdata[ADCSEQ_CTRL_START]
                         && st.state == ADCSEQ_IDLE) begin
               // start is not held off; settled shows readiness
               next_st.state = ADCSEQ_CONV;
               next_st.conv_cnt = '0;
            end
         end else if (paddr == ADCSEQ_CONV_OFS) begin
            if (cfg_ok) begin
               next_st.cfg.osr_log = pwdata[3:0];
               next_st.cfg.nel_log = pwdata[5:4];
            end else begin
               ev[ADCSEQ_IRQ_BADCFG] = 1'b1;
               next_st.err = 1'b1;
            end
            next_st.fs_div = pwdata[15:8];
         end else if (paddr == ADCSEQ_BIAS_OFS) begin
            next_st.bias.gain_stage_bias_sel = pwdata[1:0];
            next_st.bias.converter_bias_sel = pwdata[3:2];
         end else if (paddr >= ADCSEQ_FE_OFS
                      && paddr < ADCSEQ_STATUS_OFS) begin
            // bytes 0..3 of this word read back regs 0..3; the next word (status bits 12:9) holds bits 3:0 of reg 4
         end else if (paddr == ADCSEQ_IRQ_EN_OFS) begin
            next_st.irq_en = pwdata[ADCSEQ_IRQ_W-1:0];
         end else if (paddr == ADCSEQ_IRQ_CLR_OFS) begin
            next_st.irq_st = st.irq_st & ~pwdata[ADCSEQ_IRQ_W-1:0];
         end else if (paddr != ADCSEQ_STATUS_OFS
                      && paddr != ADCSEQ_IRQ_ST_OFS) begin
            next_st.err = 1'b1;
         end
      end

      // frontend config: one register index per write, any write resets
      if (wr && paddr == ADCSEQ_FE_OFS) begin
         if (pwdata[11:8] < ADCSEQ_FE_CNT[3:0]) begin
            next_st.fe_reg[pwdata[10:8]] = pwdata[7:0];
         end
         next_st.pga_rst = 1'b1;
         next_st.settle_cnt = '0;
      end

      // events: set wins over clear
      next_st.irq_st = next_st.irq_st | ev;

      // read data captured in setup, presented in access
      next_st.rdata = '0;
      if (rd) begin
         if (paddr == ADCSEQ_CTRL_OFS) begin
            next_st.rdata[ADCSEQ_CTRL_CONT] = st.cont;
            next_st.rdata[ADCSEQ_CTRL_BYPASS] = st.bypass;
         end else if (paddr == ADCSEQ_CONV_OFS) begin
            next_st.rdata[5:0] = {st.cfg.nel_log, st.cfg.osr_log};
            next_st.rdata[15:8] = st.fs_div;
         end else if (paddr == ADCSEQ_BIAS_OFS) begin
            next_st.rdata[3:0] = {st.bias.converter_bias_sel,
                                  st.bias.gain_stage_bias_sel};
         end else if (paddr == ADCSEQ_FE_OFS) begin
            next_st.rdata = {st.fe_reg[3], st.fe_reg[2],
                             st.fe_reg[1], st.fe_reg[0]};
         end else if (paddr == ADCSEQ_STATUS_OFS) begin
            next_st.rdata[2:0] = st.state;
            next_st.rdata[3] = settled;
            next_st.rdata[8:4] = resolution;
            next_st.rdata[15:9] = {3'h0, st.fe_reg[4][3:0]};
         end else if (paddr == ADCSEQ_IRQ_ST_OFS) begin
            next_st.rdata[ADCSEQ_IRQ_W-1:0] = st.irq_st;
         end else if (paddr == ADCSEQ_IRQ_EN_OFS) begin
            next_st.rdata[ADCSEQ_IRQ_W-1:0] = st.irq_en;
         end else if (paddr != ADCSEQ_IRQ_CLR_OFS) begin
            next_st.err = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.state <= ADCSEQ_STARTUP;
         st.cfg.osr_log <= ADCSEQ_OSR_LOG_RST;
         st.cfg.nel_log <= ADCSEQ_NEL_LOG_RST;
         st.bias <= {ADCSEQ_BIAS_RST, ADCSEQ_BIAS_RST};
         st.fs_div <= FS_DIV_RST;
         st.pga_rst <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // bypassed gain stages need no settling
   assign settled = st.bypass
      || (st.settle_cnt >= osr_val);
   assign resolution = 5'({st.cfg.osr_log, 1'b0})
      + 5'(st.cfg.nel_log);
   assign conv_done = (st.state == ADCSEQ_DONE);
   assign gain_stage_reset = st.pga_rst;
   assign osc_enable = (st.state != ADCSEQ_SLEEP);
   assign irq = |(st.irq_st & st.irq_en);
   assign prdata = st.rdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & st.err;
endmodule

// File: src/adcseq_bias_map.sv
// two-bit bias code to bias level decode
`timescale 1ns/1ns
module adcseq_bias_map
   import adcseq_pkg::*;
(
   input  wire logic [1:0] sel,
   output logic [3:0]      level
);
   // one-hot: full, three quarters, half, quarter
   always_comb begin
      case (sel)
         ADCSEQ_BIAS_FULL: level = 4'h8;
         ADCSEQ_BIAS_3Q:   level = 4'h4;
         ADCSEQ_BIAS_HALF: level = 4'h2;
         default:          level = 4'h1;
      endcase
   end
endmodule

// File: src/adcseq_fs_div.sv
// sampling clock enable divider
`timescale 1ns/1ns
module adcseq_fs_div
   import adcseq_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [7:0] div,
   output logic            fs_tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } adcseq_div_st_t;
   adcseq_div_st_t st;
   adcseq_div_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!run) begin
         next_st.cnt = 8'h00;
      end else if (st.cnt >= div) begin
         next_st.cnt = 8'h00;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign fs_tick = st.tick;
endmodule

// File: src/adcseq_pkg.sv
// package: register map, field layouts, timing constants and types
package adcseq_pkg;
   // register byte offsets
   localparam logic [11:0] ADCSEQ_CTRL_OFS    = 12'h000;
   localparam logic [11:0] ADCSEQ_CONV_OFS    = 12'h004;
   localparam logic [11:0] ADCSEQ_BIAS_OFS    = 12'h008;
   localparam logic [11:0] ADCSEQ_FE_OFS      = 12'h00C;
   localparam logic [11:0] ADCSEQ_STATUS_OFS  = 12'h010;
   localparam logic [11:0] ADCSEQ_IRQ_ST_OFS  = 12'h014;
   localparam logic [11:0] ADCSEQ_IRQ_EN_OFS  = 12'h018;
   localparam logic [11:0] ADCSEQ_IRQ_CLR_OFS = 12'h01C;
   localparam logic [11:0] ADCSEQ_FE_CNT      = 12'h005;
   // control bits
   localparam int ADCSEQ_CTRL_START  = 0;
   localparam int ADCSEQ_CTRL_CONT   = 1;
   localparam int ADCSEQ_CTRL_SWRST  = 2;
   localparam int ADCSEQ_CTRL_WAKE   = 3;
   localparam int ADCSEQ_CTRL_SLEEP  = 4;
   localparam int ADCSEQ_CTRL_BYPASS = 5;
   // interrupt bits
   localparam int ADCSEQ_IRQ_EOC     = 0;
   localparam int ADCSEQ_IRQ_READY   = 1;
   localparam int ADCSEQ_IRQ_BADCFG  = 2;
   localparam int ADCSEQ_IRQ_W       = 3;
   // conversion settings (log2 codes)
   localparam logic [3:0] ADCSEQ_OSR_LOG_MIN = 4'h3;
   localparam logic [3:0] ADCSEQ_OSR_LOG_MAX = 4'hA;
   localparam logic [1:0] ADCSEQ_NEL_LOG_MAX = 2'h3;
   localparam logic [3:0] ADCSEQ_OSR_LOG_RST = 4'h5;
   localparam logic [1:0] ADCSEQ_NEL_LOG_RST = 2'h0;
   localparam logic [1:0] ADCSEQ_BIAS_RST    = 2'h3;
   localparam logic [1:0] ADCSEQ_BIAS_FULL   = 2'h3;
   localparam logic [1:0] ADCSEQ_BIAS_3Q     = 2'h2;
   localparam logic [1:0] ADCSEQ_BIAS_HALF   = 2'h1;
   localparam logic [1:0] ADCSEQ_BIAS_QTR    = 2'h0;
   // timing
   localparam int CLK_MHZ              = 50;
   localparam int POWER_ON_STARTUP_US  = 800;
   localparam int OSC_ENABLE_US        = 450;
   localparam int STARTUP_CYC = POWER_ON_STARTUP_US * CLK_MHZ;
   localparam int OSC_CYC     = OSC_ENABLE_US * CLK_MHZ;
   localparam logic [7:0] FS_DIV_RST   = 8'h63;
   localparam int CNT_W = 16;

   typedef enum logic [2:0] {
      ADCSEQ_SLEEP, ADCSEQ_WAKING, ADCSEQ_STARTUP,
      ADCSEQ_IDLE, ADCSEQ_CONV, ADCSEQ_DONE
   } adcseq_state_t;

   typedef struct packed {
      logic [3:0] osr_log;
      logic [1:0] nel_log;
   } adcseq_conv_cfg_t;

   typedef struct packed {
      logic [1:0] gain_stage_bias_sel;
      logic [1:0] converter_bias_sel;
   } adcseq_bias_t;
endpackage
